// *** rtl/fst_pkg.sv ***
// Constants for the frequency select table control block
package fst_pkg;
  localparam int REF_DIV_W = 8;
  localparam int FB_DIV_W = 11;
  localparam int OUT_DIV_W = 7;
  localparam int CAP_W = 6;
  localparam int DRV_W = 2;
  localparam int ROWS = 8;
  localparam int IDX_W = 3;
  localparam int ROW_W = REF_DIV_W + FB_DIV_W + 1;
  // Row layout: {bank choice, feedback divider, reference divider}
  localparam int ROW_Q_LSB = 0;
  localparam int ROW_P_LSB = REF_DIV_W;
  localparam int ROW_BANK_BIT = REF_DIV_W + FB_DIV_W;
  // Post-ratio field codes
  localparam logic [1:0] E_OFF = 2'h0;
  localparam logic [1:0] E_DIV4 = 2'h1;
  localparam logic [1:0] E_DIV2 = 2'h2;
  localparam logic [1:0] E_DIV3 = 2'h3;
  // Load capacitance: 6 pF base, 0.375 pF per step, in thousandths of a pF
  localparam int CAP_BASE_MPF = 6000;
  localparam int CAP_STEP_MPF = 375;
  localparam int CAP_MAX_MPF = 30000;
  localparam logic [CAP_W-1:0] CAP_RESET = 6'h00;
  localparam logic [DRV_W-1:0] DRV_RESET = 2'h0;
  // Start-up: cycles after reset release before the low index bits are frozen
  localparam logic [3:0] CAPTURE_DELAY = 4'h4;
endpackage

// *** rtl/fst_ctrl.sv ***
// Frequency select table control of a three-synthesizer clock generator
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Synthesizers use 8-bit reference, 11-bit feedback dividers
// - Synth one feeds switch and E post-divider
// - Synth one and the A/B bank choice follow the select inputs
// - High select swaps synth one, A, B
// - Eight-row table indexed by three selects
// - Serial pins captured at start-up as low index
// - A and B share one bank choice
// - Each table row names the A/B bank
// - Bank switch on high select is glitch-free
// - Shutdown low tristates outputs, optionally keeps running
// - Suspend pin is index bit 2 or suspend
// - Six-bit load cap, 0.375 pF steps, 6-30 pF
// - Option bypasses on-die load capacitors
// - Oscillator drive strength is programmable
// - Buffered reference drives dedicated output
// - E ratio: 00 off, 01 /4, 10 /2, 11 /3
// - Zero output divider powers down and tristates
// - Divider bytes take effect at their acknowledge
module fst_ctrl #(
  parameter int ROWS = fst_pkg::ROWS
) (
  input wire logic mclk, // reference clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic serial_data_pin, // pin, low index at start-up
  input wire logic serial_clock_pin, // pin, mid index at start-up
  input wire logic suspend_pin, // pin, index bit 2 or suspend
  input wire logic shutdown_oe_n, // pin, low disables outputs
  input wire logic shutdown_tristate_only, // option: keep chip running
  input wire logic suspend_mode_en, // option: pin is suspend
  input wire logic cfg_we, // table row write, at byte acknowledge
  input wire logic [fst_pkg::IDX_W-1:0] cfg_row, // row being written
  input wire logic [fst_pkg::REF_DIV_W-1:0] cfg_ref_div, // row reference divider
  input wire logic [fst_pkg::FB_DIV_W-1:0] cfg_fb_div, // row feedback divider
  input wire logic cfg_bank, // row A/B bank choice
  input wire logic [fst_pkg::OUT_DIV_W-1:0] a_div0, // A divider bank 0
  input wire logic [fst_pkg::OUT_DIV_W-1:0] a_div1, // A divider bank 1
  input wire logic [fst_pkg::OUT_DIV_W-1:0] b_div0, // B divider bank 0
  input wire logic [fst_pkg::OUT_DIV_W-1:0] b_div1, // B divider bank 1
  input wire logic [1:0] e_post_ratio, // E post-divider code
  input wire logic [fst_pkg::CAP_W-1:0] cap_code, // load capacitance code
  input wire logic cap_bypass, // bypass load caps, driven input
  input wire logic [fst_pkg::DRV_W-1:0] drive_code, // inverter drive strength
  input wire logic synth_one_clk, // synth one output (modelled as enable)
  output logic [fst_pkg::REF_DIV_W-1:0] synth_one_ref_div, // applied Q
  output logic [fst_pkg::FB_DIV_W-1:0] synth_one_fb_div, // applied P
  output logic ab_bank_choice, // active A/B bank
  output logic [fst_pkg::OUT_DIV_W-1:0] a_div_act, // applied A divider
  output logic [fst_pkg::OUT_DIV_W-1:0] b_div_act, // applied B divider
  output logic a_out_en, // A output driven
  output logic b_out_en, // B output driven
  output logic out_clock_e, // E clock
  output logic e_out_en, // E output driven
  output logic out_enable, // outputs not tristated by the shutdown pin
  output logic chip_run, // chip not shut down
  output logic suspend_active, // suspend requested
  output logic [fst_pkg::CAP_W-1:0] cap_applied, // load cap setting
  output logic cap_bypass_r, // load caps bypassed
  output logic [fst_pkg::DRV_W-1:0] drive_applied, // drive strength
  output logic ref_buf_out // buffered reference enable
);
  typedef enum logic [1:0] {ST_WAIT, ST_RUN} fst_st_e;

  // Three-stage pin synchronisers; stage one feeds only stage two
  logic [2:0] sd_s, sc_s, su_s, sh_s;
  logic sd_q, sc_q, su_q, sh_q;
  fst_st_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [1:0] low_idx_r, low_idx_nxt;
  logic [fst_pkg::ROW_W-1:0] table_r [ROWS], table_nxt [ROWS];
  logic [2:0] e_cnt_r, e_cnt_nxt;
  logic e_clk_nxt;
  logic bank_r, bank_nxt;
  logic [fst_pkg::IDX_W-1:0] idx;
  logic [fst_pkg::ROW_W-1:0] row;
  logic [2:0] e_top;

  always_ff @(posedge mclk) begin
    sd_s <= {sd_s[1:0], serial_data_pin};
    sc_s <= {sc_s[1:0], serial_clock_pin};
    su_s <= {su_s[1:0], suspend_pin};
    sh_s <= {sh_s[1:0], shutdown_oe_n};
    if (sd_s[2] == sd_s[1]) sd_q <= sd_s[2];
    if (sc_s[2] == sc_s[1]) sc_q <= sc_s[2];
    if (su_s[2] == su_s[1]) su_q <= su_s[2];
    if (sh_s[2] == sh_s[1]) sh_q <= sh_s[2];
  end

  // Start-up capture of the low index
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    low_idx_nxt = low_idx_r;
    case (st_r)
      ST_WAIT: begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == fst_pkg::CAPTURE_DELAY) begin
          low_idx_nxt = {sc_q, sd_q};
          st_nxt = ST_RUN;
        end
      end
      ST_RUN: low_idx_nxt = low_idx_r;
      default: st_nxt = ST_WAIT;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= ST_WAIT;
      cnt_r <= 4'h0;
      low_idx_r <= 2'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      low_idx_r <= low_idx_nxt;
    end
  end

  // Table storage; a row write lands the cycle its byte is acknowledged
  always_comb begin
    for (int i = 0; i < ROWS; i++) table_nxt[i] = table_r[i];
    if (cfg_we) table_nxt[cfg_row] = {cfg_bank, cfg_fb_div, cfg_ref_div};
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < ROWS; i++) begin
      if (sys_rst) table_r[i] <= '0;
      else table_r[i] <= table_nxt[i];
    end
  end

  // Suspend mode takes the pin away from the index
  assign idx = {(suspend_mode_en ? 1'b0 : su_q), low_idx_r};
  assign row = table_r[idx];

  // Bank changes only while the E divider restarts, so no short pulse
  // is emitted mid-period; A/B dividers switch banks at that same E restart.
  always_comb begin
    e_top = 3'h1;
    case (e_post_ratio)
      fst_pkg::E_DIV2: e_top = 3'h1;
      fst_pkg::E_DIV3: e_top = 3'h2;
      fst_pkg::E_DIV4: e_top = 3'h3;
      default: e_top = 3'h1;
    endcase
    e_cnt_nxt = (e_cnt_r >= e_top) ? 3'h0 : e_cnt_r + 3'h1;
    if (!synth_one_clk) e_cnt_nxt = e_cnt_r;
    e_clk_nxt = (e_post_ratio != fst_pkg::E_OFF) && (e_cnt_nxt < (e_top + 3'h1) / 3'h2);
    bank_nxt = (e_cnt_nxt == 3'h0) ? row[fst_pkg::ROW_BANK_BIT] : bank_r;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      e_cnt_r <= 3'h0;
      out_clock_e <= 1'b0;
      bank_r <= 1'b0;
      synth_one_ref_div <= '0;
      synth_one_fb_div <= '0;
      ab_bank_choice <= 1'b0;
      a_div_act <= '0;
      b_div_act <= '0;
      a_out_en <= 1'b0;
      b_out_en <= 1'b0;
      e_out_en <= 1'b0;
      out_enable <= 1'b0;
      chip_run <= 1'b0;
      suspend_active <= 1'b0;
      cap_applied <= fst_pkg::CAP_RESET;
      cap_bypass_r <= 1'b0;
      drive_applied <= fst_pkg::DRV_RESET;
      ref_buf_out <= 1'b0;
    end else begin
      e_cnt_r <= e_cnt_nxt;
      out_clock_e <= e_clk_nxt;
      bank_r <= bank_nxt;
      synth_one_ref_div <= row[fst_pkg::ROW_Q_LSB +: fst_pkg::REF_DIV_W];
      synth_one_fb_div <= row[fst_pkg::ROW_P_LSB +: fst_pkg::FB_DIV_W];
      ab_bank_choice <= bank_nxt;
      a_div_act <= bank_nxt ? a_div1 : a_div0;
      b_div_act <= bank_nxt ? b_div1 : b_div0;
      a_out_en <= sh_q && ((bank_nxt ? a_div1 : a_div0) != '0);
      b_out_en <= sh_q && ((bank_nxt ? b_div1 : b_div0) != '0);
      e_out_en <= sh_q && (e_post_ratio != fst_pkg::E_OFF);
      out_enable <= sh_q;
      chip_run <= sh_q || shutdown_tristate_only;
      suspend_active <= suspend_mode_en && !su_q;
      cap_applied <= cap_code;
      cap_bypass_r <= cap_bypass;
      drive_applied <= drive_code;
      ref_buf_out <= sh_q;
    end
  end

  a_low_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r == ST_RUN) |=> $stable(low_idx_r)) else $error("low index moved");
  a_e_off: assert property (@(posedge mclk) disable iff (sys_rst)
    (e_post_ratio == fst_pkg::E_OFF) |=> !out_clock_e) else $error("E not off");
  a_oe_low: assert property (@(posedge mclk) disable iff (sys_rst)
    !sh_q |=> !out_enable && !a_out_en) else $error("outputs not tristated");
  a_zero_div: assert property (@(posedge mclk) disable iff (sys_rst)
    (a_div_act == '0) |-> !a_out_en) else $error("zero divider drives");
  a_bank_same: assert property (@(posedge mclk) disable iff (sys_rst)
    ab_bank_choice == bank_r) else $error("bank mismatch");
  a_bank_edge: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(bank_r) |-> e_cnt_r == 3'h0) else $error("bank changed mid period");
  a_run_opt: assert property (@(posedge mclk) disable iff (sys_rst)
    shutdown_tristate_only |=> chip_run) else $error("chip shut down");
  a_low_capture: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r == ST_WAIT && cnt_r == fst_pkg::CAPTURE_DELAY) |=>
    low_idx_r == {$past(sc_q), $past(sd_q)}) else $error("capture wrong");
  c_run: cover property (@(posedge mclk) st_r == ST_RUN);
  c_suspend: cover property (@(posedge mclk) $rose(suspend_active));
  c_bank: cover property (@(posedge mclk) $rose(bank_r));
  c_shut: cover property (@(posedge mclk) $fell(out_enable));
endmodule
`default_nettype wire

// *** sim/fst_board_model.sv ***
// Board logic model driving the select and shutdown pins
`timescale 1ns/1ps
`default_nettype none
module fst_board_model (
  input wire logic mclk, // reference clock
  input wire logic [2:0] req_idx, // wanted levels: high, mid, low select
  input wire logic req_oe, // wanted shutdown pin level
  output logic serial_data_pin, // low index pin
  output logic serial_clock_pin, // mid index pin
  output logic suspend_pin, // high index pin
  output logic shutdown_oe_n // output enable pin
);
  // Pins move at falling edges only, well away from the sampling edge
  always @(negedge mclk) begin
    {suspend_pin, serial_clock_pin, serial_data_pin} <= req_idx;
    shutdown_oe_n <= req_oe;
  end
endmodule
`default_nettype wire

// *** sim/fst_ctrl_tb_top.sv ***
// Self-checking bench for the frequency select table control
`timescale 1ns/1ps
`default_nettype none
module fst_ctrl_tb_top;
  logic mclk = 0, sys_rst = 1, cfg_we = 0, cfg_bank = 0, cap_bypass = 0, synth_one_clk = 1;
  logic shutdown_tristate_only = 0, suspend_mode_en = 0, req_oe = 1;
  logic serial_data_pin, serial_clock_pin, suspend_pin, shutdown_oe_n;
  logic [2:0] req_idx = 3'h5, cfg_row = 3'h0;
  logic [7:0] cfg_ref_div = 8'h00, synth_one_ref_div;
  logic [10:0] cfg_fb_div = 11'h000, synth_one_fb_div;
  logic [6:0] a_div0 = 7'h03, a_div1 = 7'h05, b_div0 = 7'h07, b_div1 = 7'h09;
  logic [6:0] a_div_act, b_div_act;
  logic [1:0] e_post_ratio = 2'h2, drive_code = 2'h0, drive_applied;
  logic [5:0] cap_code = 6'h00, cap_applied;
  logic ab_bank_choice, a_out_en, b_out_en, out_clock_e, e_out_en, out_enable, chip_run;
  logic suspend_active, cap_bypass_r, ref_buf_out;
  logic [19:0] rows [8];
  int miscompares = 0, n_tests = 0, rises;
  fst_board_model board (.mclk, .req_idx, .req_oe, .serial_data_pin, .serial_clock_pin,
    .suspend_pin, .shutdown_oe_n);
  fst_ctrl dut (.mclk, .sys_rst, .serial_data_pin, .serial_clock_pin, .suspend_pin,
    .shutdown_oe_n, .shutdown_tristate_only, .suspend_mode_en, .cfg_we, .cfg_row,
    .cfg_ref_div, .cfg_fb_div, .cfg_bank, .a_div0, .a_div1, .b_div0, .b_div1, .e_post_ratio,
    .cap_code, .cap_bypass, .drive_code, .synth_one_clk, .synth_one_ref_div,
    .synth_one_fb_div, .ab_bank_choice, .a_div_act, .b_div_act, .a_out_en, .b_out_en,
    .out_clock_e, .e_out_en, .out_enable, .chip_run, .suspend_active, .cap_applied,
    .cap_bypass_r, .drive_applied, .ref_buf_out);
  initial forever #2.5 mclk = ~mclk;
  function automatic int e_rises(input int code, input int n);
    case (code)
      1: return n / 4;
      2: return n / 2;
      3: return n / 3;
      default: return 0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Row 1 alone uses bank 1, so a swap of the high select moves the bank
  task automatic load_table;
    for (int i = 0; i < 8; i++) begin
      rows[i] = 20'($urandom);
      rows[i][19] = (i == 1);
      {cfg_bank, cfg_fb_div, cfg_ref_div} = rows[i];
      cfg_row = i[2:0];
      cfg_we = 1;
      cyc(1);
    end
    cfg_we = 0;
  endtask
  task automatic count_rises(input int n, output int r);
    logic p;
    r = 0;
    p = out_clock_e;
    repeat (n) begin
      cyc(1);
      if (out_clock_e === 1'b1 && p === 1'b0) r++;
      p = out_clock_e;
    end
  endtask
  task automatic chk_row(input logic [2:0] i);
    chk(synth_one_ref_div, rows[i][7:0]);
    chk(synth_one_fb_div, rows[i][18:8]);
    chk(ab_bank_choice, rows[i][19]);
    chk(a_div_act, rows[i][19] ? a_div1 : a_div0);
    chk(b_div_act, rows[i][19] ? b_div1 : b_div0);
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Whole run is about a thousand cycles; four thousand leaves margin
  initial begin
    #(5 * 4000);
    miscompares++;
    end_sim();
  end
  initial begin
    void'($urandom(28025));
    cyc(20);
    sys_rst = 0;
    cyc(10);
    req_idx = 3'h6; // Serial pins move after the start-up capture
    load_table();
    cyc(30);
    chk_row(3'h5);
    req_idx = 3'h2;
    cyc(30);
    chk_row(3'h1);
    for (int c = 0; c < 4; c++) begin
      e_post_ratio = c[1:0];
      cyc(20);
      count_rises(120, rises);
      chk(rises, e_rises(c, 120));
      chk(e_out_en, c != 0);
    end
    synth_one_clk = 0; // A stalled synth one must leave E still
    cyc(2);
    count_rises(40, rises);
    chk(rises, 0);
    synth_one_clk = 1;
    req_idx = 3'h6;
    a_div0 = 7'h00; // Zero divider on the bank row 5 uses
    cyc(30);
    chk_row(3'h5);
    chk({a_out_en, b_out_en}, 2'h1);
    a_div0 = 7'h03;
    repeat (6) begin
      {cap_bypass, drive_code, cap_code} = 9'($urandom);
      cyc(3);
      chk({cap_bypass_r, drive_applied, cap_applied}, {cap_bypass, drive_code, cap_code});
    end
    suspend_mode_en = 1;
    cyc(30);
    chk_row(3'h1);
    chk(suspend_active, 1'b0);
    req_idx = 3'h2; // Suspend pin low now asks for suspend
    cyc(10);
    chk(suspend_active, 1'b1);
    chk_row(3'h1);
    req_idx = 3'h6;
    req_oe = 0;
    cyc(10);
    chk({out_enable, chip_run}, 2'h0);
    chk(ref_buf_out, 1'b0);
    shutdown_tristate_only = 1;
    cyc(5);
    chk({out_enable, chip_run}, 2'h1);
    req_oe = 1;
    cyc(10);
    chk(out_enable, 1'b1);
    chk(ref_buf_out, 1'b1);
    sys_rst = 1; // Second start-up latches the serial pins as they stand now
    cyc(5);
    sys_rst = 0;
    cyc(10);
    load_table();
    cyc(30);
    chk_row(3'h2);
    req_idx = 3'h4;
    cyc(20);
    chk_row(3'h2);
    end_sim();
  end
endmodule
`default_nettype wire
